// >>> dv/spi_slave_model.sv
// behavioural spi slave facing the master spi serial port
`timescale 1ns/100ps
`default_nettype none
module spi_slave_model (
  // mode and selection
  input wire logic i_en,
  input wire logic i_cpha,
  input wire logic i_order,
  // spi pins
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // captured bytes
  output logic [7:0] o_rx_byte,
  output logic [7:0] o_frames
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic [2:0] bi;
  logic [7:0] rep;
  // *************
  // edge counting
  // *************
  initial begin
    o_frames = 8'h00;
    o_rx_byte = 8'h00;
  end
  // reply changes per frame so a lost byte shows; noise before a phase-one frame
  assign rep = 8'hC6 + o_frames;
  assign bi = 3'((cnt - int'(i_cpha)) / 2);
  assign o_miso = (i_cpha && cnt == 0) ? ~o_frames[0] : rep[i_order ? bi : 3'h7 - bi];
  // every sck change is an edge, sixteen a frame; ignored while the pin is not owned
  always @(i_sck) begin
    if (i_en) begin
      if (cnt % 2 == int'(i_cpha)) begin
        sh[i_order ? bi : 3'h7 - bi] = i_mosi;
      end
      cnt = cnt + 1;
      if (cnt == 16) begin
        cnt = 0;
        o_rx_byte = sh;
        o_frames = o_frames + 8'h01;
      end
    end
  end
endmodule : spi_slave_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the master spi serial port
`timescale 1ns/100ps
`default_nettype none
`include "usart_spi_defs.svh"
module tb;
  import usart_spi_pkg::*;
  logic i_mclk, i_rst, glob, ack, cpha, order, miso, sck, oe, mosi, take;
  logic rxc_irq, txc_irq, udre_irq;
  logic [7:0] rdata, rxb, frames;
  logic [7:0] fr = 8'h00;
  reg_req_s req;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // ******************
  // design and partner
  // ******************
  usart_master_spi i_usart_master_spi (.i_mclk, .i_rst, .i_req(req), .o_rdata(rdata),
    .i_global_irq_en(glob), .i_txc_irq_ack(ack), .o_rxc_irq(rxc_irq), .o_txc_irq(txc_irq),
    .o_udre_irq(udre_irq), .o_serial_output_pin(mosi), .o_serial_output_oe(oe),
    .i_serial_input_pin(miso), .o_transfer_clock_pin(sck), .o_serial_input_takeover(take));
  spi_slave_model i_spi_slave_model (.i_en(oe), .i_cpha(cpha), .i_order(order), .i_sck(sck),
    .i_mosi(mosi), .o_miso(miso), .o_rx_byte(rxb), .o_frames(frames));
  // 50 ns clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // hang guard, far above the fifteen hundred or so cycles the run needs
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  // verdict and comparison
  task give_verdict();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // register port cycles, one idle cycle between requests
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    req <= '0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    req <= '0;
    #1 v = rdata;
  endtask : rd
  task rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rchk
  task wait_bit(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 200 && s[b] !== 1'b1; n++) rd(`REG_STATUS_A, s);
  endtask : wait_bit
  task pause(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : pause
  task chk_irq(input logic [2:0] e);
    #1;
    chk({5'h00, rxc_irq, txc_irq, udre_irq}, {5'h00, e});
    @(posedge i_mclk);
  endtask : chk_irq
  // format changes only with the transmitter off, so the clock rest level moves quietly
  task cfg(input logic [7:0] c);
    wr(`REG_CONTROL_B, 8'h00);
    wr(`REG_CONTROL_C, c);
    wr(`REG_CONTROL_B, 8'h18);
    cpha <= c[1];
    order <= c[2];
  endtask : cfg
  // *********
  // scenarios
  // *********
  task t_reset();
    chk({6'h00, mosi, sck}, 8'h02);
    rchk(`REG_STATUS_A, 8'h20);
    rchk(`REG_CONTROL_B, 8'h06);
    rchk(`REG_CONTROL_C, 8'h06);
    rchk(3'h7, 8'h00);
    wr(`REG_BAUD_LO, 8'h03);
  endtask : t_reset
  task t_modes();
    logic [7:0] d;
    for (int k = 0; k < 8; k++) begin
      d = 8'h2C + 8'(k);
      cfg({5'h18, 3'(k)});
      wr(`REG_DATA, d);
      wait_bit(7);
      chk({5'h00, oe, take, sck}, {5'h00, 2'h3, k[0]});
      rchk(`REG_STATUS_A, 8'hE0);
      rchk(`REG_DATA, 8'hC6 + fr);
      chk(rxb, d);
      fr = fr + 8'h01;
      wr(`REG_STATUS_A, 8'h40);
      rchk(`REG_STATUS_A, 8'h20);
    end
  endtask : t_modes
  task t_overflow();
    cfg(8'hC0);
    for (int k = 0; k < 4; k++) begin
      wait_bit(5);
      wr(`REG_DATA, 8'h70 + 8'(k));
    end
    wait_bit(6);
    rchk(`REG_DATA, 8'hC6 + fr);
    wr(`REG_CONTROL_B, 8'hF8);
    glob <= 1'b1;
    pause(3);
    chk_irq(3'h7);
    ack <= 1'b1;
    pause(1);
    ack <= 1'b0;
    pause(3);
    chk_irq(3'h5);
    glob <= 1'b0;
    pause(3);
    chk_irq(3'h0);
    rchk(`REG_DATA, 8'hC7 + fr);
    // one byte left unread, so the flush has something to drop
    wr(`REG_DATA, 8'h77);
    wait_bit(7);
    fr = fr + 8'h05;
    wr(`REG_CONTROL_B, 8'h08);
    rchk(`REG_STATUS_A, 8'h60);
    wr(`REG_STATUS_A, 8'h40);
  endtask : t_overflow
  task t_drain();
    cfg(8'hC4);
    wr(`REG_DATA, 8'h5A);
    wr(`REG_DATA, 8'hB4);
    wr(`REG_CONTROL_B, 8'h00);
    wait_bit(6);
    pause(2);
    fr = fr + 8'h02;
    chk(rxb, 8'hB4);
    chk({6'h00, oe, take}, 8'h00);
    chk(frames, fr);
  endtask : t_drain
  task t_mode_off();
    for (int m = 0; m < 3; m++) begin
      wr(`REG_CONTROL_B, 8'h00);
      wr(`REG_CONTROL_C, {2'(m), 6'h00});
      wr(`REG_CONTROL_B, 8'h08);
      wr(`REG_DATA, 8'h33);
      pause(100);
      chk(frames, fr);
    end
  endtask : t_mode_off
  // main sequence
  initial begin
    req = '0;
    glob = 1'b0;
    ack = 1'b0;
    cpha = 1'b0;
    order = 1'b0;
    i_rst = 1'b1;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_reset();
    t_modes();
    t_overflow();
    t_drain();
    t_mode_off();
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// >>> dv/usart_master_spi_chk.sv
// port checker of the master spi serial port
`timescale 1ns/100ps
`default_nettype none
`include "usart_spi_defs.svh"
module usart_master_spi_chk
  import usart_spi_pkg::*;
(
  // clock, reset, register and irq side
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire reg_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_global_irq_en,
  input wire logic i_txc_irq_ack,
  input wire logic o_rxc_irq,
  input wire logic o_txc_irq,
  input wire logic o_udre_irq,
  // spi pins
  input wire logic o_serial_output_pin,
  input wire logic o_serial_output_oe,
  input wire logic i_serial_input_pin,
  input wire logic o_transfer_clock_pin,
  input wire logic o_serial_input_takeover
);
  // **********
  // properties
  // **********
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // control b write; the takeover pin lags a flop, so two cycles are allowed; oe and the flushed rx irq lag two flops, so three
  sequence s_wr_b;
    i_req.wr && i_req.addr == `REG_CONTROL_B;
  endsequence
  a_err_zero: assert property (
    i_req.rd && i_req.addr == `REG_STATUS_A |=> o_rdata[4:0] == 5'h00) else $error("err bits");
  a_rxc_gate: assert property (
    o_rxc_irq |-> $past(i_global_irq_en)) else $error("rx irq ungated");
  a_txc_gate: assert property (
    !i_global_irq_en [*2] |-> !o_txc_irq) else $error("tx irq ungated");
  a_txc_ack: assert property (
    i_txc_irq_ack |-> ##[1:2] !o_txc_irq) else $error("tx irq kept");
  a_rx_take: assert property (
    s_wr_b ##0 i_req.wdata[4] |-> ##[1:2] o_serial_input_takeover) else $error("rx pin");
  a_tx_take: assert property (
    s_wr_b ##0 i_req.wdata[3] |-> ##3 o_serial_output_oe) else $error("tx pin");
  a_rx_flush: assert property (
    s_wr_b ##0 !i_req.wdata[4] |-> ##[1:3] !o_rxc_irq) else $error("rx not flushed");
  a_idle_high: assert property (
    !o_serial_output_oe [*2] |-> o_serial_output_pin) else $error("line not high");
endmodule : usart_master_spi_chk
bind usart_master_spi usart_master_spi_chk i_chk (.i_mclk, .i_rst, .i_req, .o_rdata,
  .i_global_irq_en, .i_txc_irq_ack, .o_rxc_irq, .o_txc_irq, .o_udre_irq, .o_serial_output_pin,
  .o_serial_output_oe, .i_serial_input_pin, .o_transfer_clock_pin, .o_serial_input_takeover);
`default_nettype wire

// >>> hw/usart_master_spi.sv
// serial port in master spi mode: registers, buffers, transfer engine
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "usart_spi_defs.svh"
module usart_master_spi
  import usart_spi_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire reg_req_s i_req,
  output logic [7:0] o_rdata,
  // interrupt side
  input wire logic i_global_irq_en,
  input wire logic i_txc_irq_ack,
  output logic o_rxc_irq,
  output logic o_txc_irq,
  output logic o_udre_irq,
  // spi pins
  output logic o_serial_output_pin,
  output logic o_serial_output_oe,
  input wire logic i_serial_input_pin,
  output logic o_transfer_clock_pin,
  output logic o_serial_input_takeover
);

  // ************************************
  // registers and state
  // ************************************
  logic [7:0] ctrl_b_r;
  ctrl_c_s ctrl_c_r;
  logic [`BAUD_W-1:0] baud_r;
  logic tx_en_eff_r;
  logic [7:0] tx_buf_r;
  logic tx_full_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_mem [`RX_DEPTH];
  logic [1:0] rx_cnt_r;
  logic rx_rd_ptr_r;
  logic txc_r;
  xfer_state_e state_r;
  logic [4:0] edge_r;
  logic [`BAUD_W-1:0] div_r;
  logic phase_r;
  logic mosi_r;
  logic miso_s1_r;
  logic miso_s2_r;

  // ************************************
  // decode and transfer events
  // ************************************
  logic master_spi_mode;
  logic tick;
  logic load;
  logic frame_end;
  logic leading;
  logic sample_ev;
  logic setup_ev;
  logic [2:0] samp_idx;
  logic [2:0] set_idx;
  logic rx_push;
  logic rx_pop;
  logic wr_data;
  logic rx_en;

  // mode field decode, only 11 is spi
  assign master_spi_mode = (ctrl_c_r.port_mode_select == `MODE_MASTER_SPI);
  assign rx_en = ctrl_b_r[`BIT_RXEN];
  // half bit period from the divider
  assign tick = (state_r == ST_SHIFT) && (div_r == baud_r);
  // buffered byte enters the shifter once it is free
  assign load = (state_r == ST_IDLE) && tx_full_r && tx_en_eff_r && master_spi_mode;
  // even edge counts are leading edges
  assign leading = ~edge_r[0];
  // phase selects which edge samples
  assign sample_ev = tick && (leading ^ ctrl_c_r.clock_phase_select);
  assign setup_ev = tick && ~(leading ^ ctrl_c_r.clock_phase_select);
  assign frame_end = tick && (edge_r == `FRAME_EDGES - 5'h01);
  assign samp_idx = edge_r[3:1];
  // phase 0 presents the next bit on the trailing edge
  assign set_idx = ctrl_c_r.clock_phase_select ? edge_r[3:1] : edge_r[3:1] + 3'h1;
  assign wr_data = i_req.wr && (i_req.addr == `REG_DATA);
  assign rx_pop = i_req.rd && (i_req.addr == `REG_DATA) && (rx_cnt_r != 2'h0);
  assign rx_push = frame_end && rx_en;

  // ************************************
  // control registers
  // ************************************
  // control b, reserved bits keep their fixed value
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_b_r <= {5'h00, `CTRL_B_RSVD};
    end else if (i_req.wr && i_req.addr == `REG_CONTROL_B) begin
      ctrl_b_r <= {i_req.wdata[7:3], `CTRL_B_RSVD};
    end
  end

  // format bits land with the mode bits in one write
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_c_r <= `CTRL_C_RESET;
    end else if (i_req.wr && i_req.addr == `REG_CONTROL_C) begin
      ctrl_c_r <= ctrl_c_s'({i_req.wdata[7:6], 3'h0, i_req.wdata[2:0]});
    end
  end

  // baud divider, no double speed bit exists
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      baud_r <= '0;
    end else if (i_req.wr && i_req.addr == `REG_BAUD_LO) begin
      baud_r[7:0] <= i_req.wdata;
    end else if (i_req.wr && i_req.addr == `REG_BAUD_HI) begin
      baud_r[`BAUD_W-1:8] <= i_req.wdata[3:0];
    end
  end

  // effective enable: on at once, off only once drained
  // pins stay owned while a cleared enable drains
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_en_eff_r <= 1'b0;
    end else if (ctrl_b_r[`BIT_TXEN]) begin
      tx_en_eff_r <= 1'b1;
    end else if (state_r == ST_IDLE && ~tx_full_r) begin
      tx_en_eff_r <= 1'b0;
    end
  end

  // ************************************
  // transmit holding buffer
  // ************************************
  // writes while full are dropped unless the buffer loads in that cycle; no collision flag is kept
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_full_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end else if (wr_data && (~tx_full_r || load) && tx_en_eff_r) begin
      tx_full_r <= 1'b1;
      tx_buf_r <= i_req.wdata;
    end else if (load) begin
      tx_full_r <= 1'b0;
    end
  end

  // ************************************
  // transfer engine
  // ************************************
  // frame sequencing over sixteen clock edges
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      edge_r <= 5'h00;
      div_r <= '0;
      phase_r <= 1'b0;
    end else if (load) begin
      state_r <= ST_SHIFT;
      edge_r <= 5'h00;
      div_r <= '0;
      phase_r <= 1'b0;
    end else if (state_r == ST_SHIFT) begin
      if (tick) begin
        div_r <= '0;
        phase_r <= ~phase_r;
        edge_r <= edge_r + 5'h01;
        if (frame_end) begin
          state_r <= ST_IDLE;
          phase_r <= 1'b0;
        end
      end else begin
        div_r <= div_r + `BAUD_W'(1);
      end
    end
  end

  // clock pin rests at the polarity level between frames
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_transfer_clock_pin <= 1'b0;
    end else begin
      o_transfer_clock_pin <= ctrl_c_r.clock_polarity_select ^ phase_r;
    end
  end

  // data out; bit picked by order select
  // the line goes high only once the last sampling edge has passed
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_sh_r <= 8'h00;
      mosi_r <= 1'b1;
    end else if (load) begin
      tx_sh_r <= tx_buf_r;
      if (!ctrl_c_r.clock_phase_select) begin
        mosi_r <= ctrl_c_r.bit_order_select ? tx_buf_r[0] : tx_buf_r[7];
      end
    end else if (frame_end && !ctrl_c_r.clock_phase_select) begin
      mosi_r <= 1'b1;
    end else if (setup_ev) begin
      mosi_r <= ctrl_c_r.bit_order_select ? tx_sh_r[set_idx] : tx_sh_r[3'h7 - set_idx];
    end else if (state_r == ST_IDLE) begin
      // phase one: last bit held past its sampling edge, then idle high
      mosi_r <= 1'b1;
    end
  end

  // input pin crosses two flops before use
  // pin lag plus synchroniser needs a divider of three or more
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= i_serial_input_pin;
      miso_s2_r <= miso_s1_r;
    end
  end

  // capture into the receive shifter on sampling edges
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_sh_r <= 8'h00;
    end else if (sample_ev) begin
      if (ctrl_c_r.bit_order_select) begin
        rx_sh_r[samp_idx] <= miso_s2_r;
      end else begin
        rx_sh_r[3'h7 - samp_idx] <= miso_s2_r;
      end
    end
  end

  // ************************************
  // receive buffer, two levels
  // ************************************
  // last bit of the frame comes straight from the synchroniser
  logic [7:0] rx_byte;
  always_comb begin
    rx_byte = rx_sh_r;
    if (ctrl_c_r.bit_order_select) begin
      rx_byte[samp_idx] = miso_s2_r;
    end else begin
      rx_byte[3'h7 - samp_idx] = miso_s2_r;
    end
  end

  // full buffer drops the newest byte, older ones survive
  // a read of an empty buffer leaves pointer and count alone
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt_r <= 2'h0;
      rx_rd_ptr_r <= 1'b0;
    end else if (!rx_en) begin
      rx_cnt_r <= 2'h0;
      rx_rd_ptr_r <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_rd_ptr_r <= ~rx_rd_ptr_r;
      end
      if (rx_push && !rx_pop && rx_cnt_r != `RX_DEPTH) begin
        rx_cnt_r <= rx_cnt_r + 2'h1;
      end else if (rx_pop && !(rx_push)) begin
        rx_cnt_r <= rx_cnt_r - 2'h1;
      end
    end
  end

  // storage written at the free slot
  always_ff @(posedge i_mclk) begin
    if (rx_push && (rx_cnt_r != `RX_DEPTH || rx_pop)) begin
      rx_mem[rx_rd_ptr_r ^ rx_cnt_r[0]] <= rx_byte;
    end
  end

  // ************************************
  // transmit complete flag
  // ************************************
  // set beats a clear in the same cycle
  // so a frame ending under an ack is never lost
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      txc_r <= 1'b0;
    end else if (frame_end && !tx_full_r) begin
      txc_r <= 1'b1;
    end else if (i_txc_irq_ack ||
                 (i_req.wr && i_req.addr == `REG_STATUS_A && i_req.wdata[`BIT_TXC])) begin
      txc_r <= 1'b0;
    end
  end

  // ************************************
  // interrupt requests and pins
  // ************************************
  // requests need local enable, global enable and flag
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rxc_irq <= 1'b0;
      o_txc_irq <= 1'b0;
      o_udre_irq <= 1'b0;
    end else begin
      o_rxc_irq <= ctrl_b_r[`BIT_RXCIE] && i_global_irq_en && (rx_cnt_r != 2'h0);
      o_txc_irq <= ctrl_b_r[`BIT_TXCIE] && i_global_irq_en && txc_r;
      o_udre_irq <= ctrl_b_r[`BIT_EMPTY_IE] && i_global_irq_en && !tx_full_r;
    end
  end

  // pin takeover follows the enables
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_output_pin <= 1'b1;
      o_serial_output_oe <= 1'b0;
      o_serial_input_takeover <= 1'b0;
    end else begin
      o_serial_output_pin <= mosi_r;
      o_serial_output_oe <= tx_en_eff_r;
      o_serial_input_takeover <= rx_en;
    end
  end

  // ************************************
  // read port
  // ************************************
  // error flag positions always read zero
  // reserved control b bits read back their fixed value
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        `REG_STATUS_A: begin
          o_rdata <= {rx_cnt_r != 2'h0, txc_r, !tx_full_r, 5'h00};
        end
        `REG_CONTROL_B: o_rdata <= ctrl_b_r;
        `REG_CONTROL_C: o_rdata <= ctrl_c_r;
        `REG_DATA: o_rdata <= (rx_cnt_r != 2'h0) ? rx_mem[rx_rd_ptr_r] : 8'h00;
        `REG_BAUD_LO: o_rdata <= baud_r[7:0];
        `REG_BAUD_HI: o_rdata <= {4'h0, baud_r[`BAUD_W-1:8]};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule : usart_master_spi
`default_nettype wire

// >>> hw/usart_spi_defs.svh
// register map, field positions, reset values and sizes of the serial port spi mode
`ifndef USART_SPI_DEFS_SVH
`define USART_SPI_DEFS_SVH
// register indices on the plain register port
`define REG_STATUS_A 3'h0
`define REG_CONTROL_B 3'h1
`define REG_CONTROL_C 3'h2
`define REG_DATA 3'h3
`define REG_BAUD_LO 3'h4
`define REG_BAUD_HI 3'h5
// status a fields
`define BIT_RXC 7
`define BIT_TXC 6
`define BIT_UDRE 5
// control b fields
`define BIT_RXCIE 7
`define BIT_TXCIE 6
`define BIT_EMPTY_IE 5
`define BIT_RXEN 4
`define BIT_TXEN 3
`define CTRL_B_RSVD 3'h6
// control c reset and mode code
`define CTRL_C_RESET 8'h06
`define MODE_MASTER_SPI 2'h3
// frame and buffer sizes, divider width
`define FRAME_EDGES 5'h10
`define RX_DEPTH 2'h2
`define BAUD_W 12
`endif

// >>> hw/usart_spi_pkg.sv
// types shared by the serial port spi mode
package usart_spi_pkg;
  // control c layout
  typedef struct packed {
    logic [1:0] port_mode_select;
    logic [2:0] rsvd;
    logic bit_order_select;
    logic clock_phase_select;
    logic clock_polarity_select;
  } ctrl_c_s;
  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_e;
endpackage : usart_spi_pkg
